// ===== logic/stm_timer.sv
// standard timer top: APB registers around the timer core
`timescale 1ns/1ps
`default_nettype none
module stm_timer #(
   parameter int CNT_W = 16
) (
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // timer pins
   input  wire logic        timer_tick,
   input  wire logic        external_trigger_pin,
   input  wire logic        capture_input_pin,
   output logic             timer_out
);
   // ==========================================================
   // registers
   stm_pkg::stm_ctrl_t ctrl_q, ctrl_d;
   logic [CNT_W-1:0]   cmpa_q, cmpa_d;
   logic [7:0]         cmpp_q, cmpp_d;
   logic               af_q, af_d, pf_q, pf_d, trig_prev_q;
   logic [31:0]        rdata_d;
   logic [CNT_W-1:0]   count;
   stm_pkg::stm_evt_t  evt;
   logic               wr, trig_edge, decoded;

   assign wr        = psel & penable & pwrite;
   assign trig_edge = external_trigger_pin & ~trig_prev_q;
   assign pready    = 1'b1;
   assign decoded   = paddr == stm_pkg::STM_CTRL_ADDR || paddr == stm_pkg::STM_CMPA_ADDR
                      || paddr == stm_pkg::STM_CMPP_ADDR || paddr == stm_pkg::STM_CNT_ADDR
                      || paddr == stm_pkg::STM_FLAG_ADDR;
   assign pslverr   = psel & penable & ~decoded;

   always_comb begin
      ctrl_d = ctrl_q;
      cmpa_d = cmpa_q;
      cmpp_d = cmpp_q;
      af_d   = af_q;
      pf_d   = pf_q;
      if (wr) begin
         case (paddr)
            stm_pkg::STM_CTRL_ADDR: ctrl_d = pwdata[stm_pkg::STM_TRIG_BIT:0];
            stm_pkg::STM_CMPA_ADDR: cmpa_d = pwdata[CNT_W-1:0];
            stm_pkg::STM_CMPP_ADDR: cmpp_d = pwdata[7:0];
            stm_pkg::STM_FLAG_ADDR: begin
               if (pwdata[stm_pkg::STM_AF_BIT]) af_d = 1'b0;
               if (pwdata[stm_pkg::STM_PF_BIT]) pf_d = 1'b0;
            end
            default: ;
         endcase
      end
      // hardware events win over software writes
      if (ctrl_q.trig_en && ctrl_q.op_mode == stm_pkg::STM_MODE_PWM
          && ctrl_q.pin_fn == stm_pkg::STM_IO_PULSE && trig_edge)
         ctrl_d.run = 1'b1;
      if (evt.run_clear) ctrl_d.run = 1'b0;
      if (evt.capture) cmpa_d = count;
      if (evt.match_a || evt.capture) af_d = 1'b1;
      if (evt.match_p) pf_d = 1'b1;
   end

   always_comb begin
      case (paddr)
         stm_pkg::STM_CTRL_ADDR: rdata_d = {22'h0, ctrl_q};
         stm_pkg::STM_CMPA_ADDR: rdata_d = {{(32-CNT_W){1'b0}}, cmpa_q};
         stm_pkg::STM_CMPP_ADDR: rdata_d = {24'h0, cmpp_q};
         stm_pkg::STM_CNT_ADDR:  rdata_d = {{(32-CNT_W){1'b0}}, count};
         stm_pkg::STM_FLAG_ADDR: rdata_d = {30'h0, pf_q, af_q};
         default:                rdata_d = 32'h0;
      endcase
   end
   assign prdata = (psel && penable && !pwrite) ? rdata_d : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q      <= stm_pkg::STM_CTRL_RST;
         cmpa_q      <= stm_pkg::STM_CMPA_RST;
         cmpp_q      <= stm_pkg::STM_CMPP_RST;
         af_q        <= 1'b0;
         pf_q        <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         ctrl_q      <= ctrl_d;
         cmpa_q      <= cmpa_d;
         cmpp_q      <= cmpp_d;
         af_q        <= af_d;
         pf_q        <= pf_d;
         trig_prev_q <= external_trigger_pin;
      end
   end

   stm_core #(.CNT_W(CNT_W)) u_core (
      .pclk    (pclk),
      .presetn (presetn),
      .ctrl    (ctrl_q),
      .cmp_a   (cmpa_q),
      .cmp_p   (cmpp_q),
      .tick    (timer_tick),
      .cap_in  (capture_input_pin),
      .count   (count),
      .evt     (evt),
      .pin_out (timer_out)
   );

   a_flag_a_set: assert property (@(posedge pclk) disable iff (!presetn)
      evt.match_a |=> af_q) else $error("compare a flag missed");
   a_flag_p_set: assert property (@(posedge pclk) disable iff (!presetn)
      evt.match_p |=> pf_q) else $error("compare p flag missed");
   a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
      evt.capture |=> cmpa_q == $past(count)) else $error("capture value wrong");
   a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
      (trig_edge && ctrl_q.trig_en && ctrl_q.op_mode == 2'h2 && ctrl_q.pin_fn == 2'h3
       && !evt.run_clear) |=> ctrl_q.run) else $error("trigger did not start");
   a_cap_no_out: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q.op_mode == 2'h1 |-> !timer_out) else $error("output in capture mode");
   a_run_zero: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ctrl_q.run) |=> count == '0) else $error("counter not zeroed");
endmodule : stm_timer
`default_nettype wire

// ===== shared/stm_pkg.sv
// package for the standard timer block: register map, field layout, modes
// ==========================================================================
// What this block does
// - PWM mode: op mode 10, pin function 10
// - one compare sets period, other sets duty
// - swap 1: period A, duty P*256 or 65536
// - duty at or above period gives 100 percent
// - clear select ignored in PWM mode
// - separate flags on compare A and P matches
// - pin function 00/01 forces pin, counting continues
// - invert bit reverses PWM pin polarity
// - single pulse: op mode 10, pin function 11
// - run rise starts counter and pulse leading edge
// - trigger pin edge sets run bit
// - compare A match clears run, ends pulse, flags
// - counter zeroed only on run rise; P ignored
// - capture mode is op mode 01, run starts
// - selected input edge copies counter to A
// - counter free runs; P match zeroes and flags
// - compare P zero lets counter wrap at max
// - pin function 11 disables capture, counter runs
// - capture mode has no output function
// - output level 0 active low, 1 active high
// - run rise resets pin to initial level
// - compare P meets counter upper eight bits only
// ==========================================================================
package stm_pkg;
   // register byte addresses on the APB
   localparam logic [11:0] STM_CTRL_ADDR = 12'h000;
   localparam logic [11:0] STM_CMPA_ADDR = 12'h004;
   localparam logic [11:0] STM_CMPP_ADDR = 12'h008;
   localparam logic [11:0] STM_CNT_ADDR  = 12'h00C;
   localparam logic [11:0] STM_FLAG_ADDR = 12'h010;
   // control register field positions
   localparam int STM_CLR_BIT  = 0;
   localparam int STM_DPX_BIT  = 1;
   localparam int STM_POL_BIT  = 2;
   localparam int STM_OC_BIT   = 3;
   localparam int STM_IO_LSB   = 4;
   localparam int STM_MODE_LSB = 6;
   localparam int STM_RUN_BIT  = 8;
   localparam int STM_TRIG_BIT = 9;
   // flag register bit positions, write one to clear
   localparam int STM_AF_BIT = 0;
   localparam int STM_PF_BIT = 1;
   // reset values
   localparam logic [9:0]  STM_CTRL_RST = 10'h000;
   localparam logic [15:0] STM_CMPA_RST = 16'h0000;
   localparam logic [7:0]  STM_CMPP_RST = 8'h00;
   // operating mode and pin function codes
   localparam logic [1:0] STM_MODE_CMP = 2'h0;
   localparam logic [1:0] STM_MODE_CAP = 2'h1;
   localparam logic [1:0] STM_MODE_PWM = 2'h2;
   localparam logic [1:0] STM_IO_INACT = 2'h0;
   localparam logic [1:0] STM_IO_ACT   = 2'h1;
   localparam logic [1:0] STM_IO_PWM   = 2'h2;
   localparam logic [1:0] STM_IO_PULSE = 2'h3;
   localparam logic [1:0] STM_EDGE_RISE = 2'h0;
   localparam logic [1:0] STM_EDGE_FALL = 2'h1;
   localparam logic [1:0] STM_EDGE_BOTH = 2'h2;

   // control fields as one carrier
   typedef struct packed {
      logic       trig_en;
      logic       run;
      logic [1:0] op_mode;
      logic [1:0] pin_fn;
      logic       out_level;
      logic       out_invert;
      logic       swap;
      logic       clr_sel;
   } stm_ctrl_t;

   // one-cycle events from the core
   typedef struct packed {
      logic match_a;
      logic match_p;
      logic capture;
      logic run_clear;
   } stm_evt_t;
endpackage : stm_pkg

// ===== logic/stm_core.sv
// timer core: counter, compares, waveform and capture
`timescale 1ns/1ps
`default_nettype none
module stm_core #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // configuration, timer tick and capture input
   input  wire stm_pkg::stm_ctrl_t ctrl,
   input  wire logic [CNT_W-1:0] cmp_a,
   input  wire logic [7:0]       cmp_p,
   input  wire logic             tick,
   input  wire logic             cap_in,
   // results
   output logic [CNT_W-1:0]      count,
   output stm_pkg::stm_evt_t     evt,
   output logic                  pin_out
);
   // ==========================================================
   // counter and compares
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             run_prev_q, cap_prev_q, act_q, act_d, pin_q, pin_d;
   logic             run_rise, is_pwm, is_pulse, is_cap;
   logic             hit_a, hit_p, edge_ok, act_raw;
   logic [16:0]      period, duty, cnt_next, p_val;

   assign run_rise = ctrl.run & ~run_prev_q;
   assign is_pwm   = ctrl.op_mode == stm_pkg::STM_MODE_PWM;
   assign is_pulse = is_pwm & (ctrl.pin_fn == stm_pkg::STM_IO_PULSE);
   assign is_cap   = ctrl.op_mode == stm_pkg::STM_MODE_CAP;
   assign cnt_next = {1'b0, cnt_q} + 17'h00001;
   assign p_val    = (cmp_p == 8'h00) ? 17'h10000 : {1'b0, cmp_p, 8'h00};
   // the compare that sets the period matches where the counter wraps, so its
   // flag still fires although the counter never shows that value itself
   assign hit_a    = tick & ((is_pwm & ~is_pulse & ctrl.swap) ? (cnt_next == {1'b0, cmp_a})
                                                              : (cnt_q == cmp_a));
   assign hit_p    = tick & ~is_pulse & ((is_pwm & ctrl.swap) ? ({1'b0, cnt_q} == p_val)
                                                              : (cnt_next == p_val));

   // period and duty in timer clocks, swap picks roles
   always_comb begin
      if (!ctrl.swap) begin
         period = (cmp_p == 8'h00) ? 17'h10000 : {1'b0, cmp_p, 8'h00};
         duty   = {1'b0, cmp_a};
      end else begin
         period = {1'b0, cmp_a};
         duty   = (cmp_p == 8'h00) ? 17'h10000 : {1'b0, cmp_p, 8'h00};
      end
   end

   always_comb begin
      cnt_d = cnt_q;
      if (run_rise) cnt_d = '0;
      else if (ctrl.run && tick) begin
         // clear select is never consulted here
         if (is_pwm && !is_pulse && ({1'b0, cnt_q} + 17'h1 >= period))
            cnt_d = '0;
         else if (is_cap && cmp_p != 8'h00 && hit_p) cnt_d = '0;
         else cnt_d = cnt_q + 1'b1;
      end
   end

   // ==========================================================
   // capture edge detect
   always_comb begin
      case (ctrl.pin_fn)
         stm_pkg::STM_EDGE_RISE: edge_ok = cap_in & ~cap_prev_q;
         stm_pkg::STM_EDGE_FALL: edge_ok = ~cap_in & cap_prev_q;
         stm_pkg::STM_EDGE_BOTH: edge_ok = cap_in ^ cap_prev_q;
         default:                edge_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // waveform
   always_comb begin
      act_raw = act_q;
      if (is_pulse) act_raw = ctrl.run;
      else if (is_pwm) act_raw = ({1'b0, cnt_q} < duty) || (duty >= period);
      act_d = act_raw;
      pin_d = pin_q;
      if (run_rise) pin_d = ~ctrl.out_level ^ ctrl.out_invert;
      else if (is_pwm && ctrl.run) begin
         case (ctrl.pin_fn)
            stm_pkg::STM_IO_INACT: pin_d = ~ctrl.out_level;
            stm_pkg::STM_IO_ACT:   pin_d = ctrl.out_level;
            default: pin_d = (act_raw ~^ ctrl.out_level) ^ ctrl.out_invert;
         endcase
      end else if (is_pulse && !ctrl.run)
         pin_d = ~ctrl.out_level ^ ctrl.out_invert;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q      <= '0;
         run_prev_q <= 1'b0;
         cap_prev_q <= 1'b0;
         act_q      <= 1'b0;
         pin_q      <= 1'b0;
      end else begin
         cnt_q      <= cnt_d;
         run_prev_q <= ctrl.run;
         cap_prev_q <= cap_in;
         act_q      <= act_d;
         pin_q      <= pin_d;
      end
   end

   assign count         = cnt_q;
   assign pin_out       = is_cap ? 1'b0 : pin_q;
   assign evt.match_a   = ctrl.run & hit_a & ~is_cap;
   assign evt.match_p   = ctrl.run & hit_p & (is_pwm | is_cap);
   assign evt.capture   = is_cap & ctrl.run & edge_ok;
   assign evt.run_clear = is_pulse & ctrl.run & hit_a & ~run_rise;

   a_pulse_ends: assert property (@(posedge pclk) disable iff (!presetn)
      evt.run_clear |=> !ctrl.run) else $error("run not cleared on match");
   a_cap_off: assert property (@(posedge pclk) disable iff (!presetn)
      (is_cap && ctrl.pin_fn == 2'h3) |-> !evt.capture) else $error("capture while off");
endmodule : stm_core
`default_nettype wire

// ===== test/stm_far_side.sv
// far side model: trigger source, capture source and output load monitor
`timescale 1ns/1ps
`default_nettype none
module stm_far_side (
   // clock and reset
   input  wire logic  pclk,
   input  wire logic  presetn,
   // commands from the bench
   input  wire logic  trig_go,
   input  wire logic  cap_level,
   input  wire logic  cnt_clr,
   // pins and high cycle count to the bench
   input  wire logic  timer_out,
   output logic       external_trigger_pin,
   output logic       capture_input_pin,
   output logic [15:0] high_cnt
);
   logic [1:0] trig_q;
   // the trigger is held two cycles so a synchronous sampler cannot miss it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_q            <= 2'h0;
         capture_input_pin <= 1'b0;
         high_cnt          <= 16'h0000;
      end else begin
         trig_q            <= trig_go ? 2'h2 : (trig_q == 2'h0 ? 2'h0 : trig_q - 2'h1);
         capture_input_pin <= cap_level;
         high_cnt          <= cnt_clr ? 16'h0000 : high_cnt + {15'h0000, timer_out};
      end
   end
   assign external_trigger_pin = (trig_q != 2'h0);
endmodule : stm_far_side
`default_nettype wire

// ===== test/tb_standard_timer_pwm_pulse_capture.sv
// testbench for the standard timer: pwm table, single pulse, capture
`timescale 1ns/1ps
`default_nettype none
module tb_standard_timer_pwm_pulse_capture;
   logic        pclk, presetn, psel, penable, pwrite, timer_tick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, timer_out, ext_trig, cap_in;
   logic        trig_go, cap_level, cnt_clr;
   logic [15:0] high_cnt, a_val;
   int          n_fail, compares, cyc;
   // pin_fn, {level, invert, swap, clr_sel}, high cycles per 512, flags
   localparam logic [23:0] ROWS [6] = '{
      {2'h2, 4'h8, 16'h0080, 2'h3},
      {2'h2, 4'hC, 16'h0180, 2'h3},
      {2'h2, 4'h1, 16'h0180, 2'h3},
      {2'h2, 4'hA, 16'h0200, 2'h1},
      {2'h0, 4'h8, 16'h0000, 2'h3},
      {2'h1, 4'h8, 16'h0200, 2'h3}};

   stm_timer #(.CNT_W(16)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
      .external_trigger_pin(ext_trig), .capture_input_pin(cap_in), .timer_out(timer_out));
   stm_far_side u_far (.pclk(pclk), .presetn(presetn), .trig_go(trig_go),
      .cap_level(cap_level), .cnt_clr(cnt_clr), .timer_out(timer_out),
      .external_trigger_pin(ext_trig), .capture_input_pin(cap_in), .high_cnt(high_cnt));

   // ==========================================================
   // shared tasks
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // clock and timeout
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, trig_go, cap_level, cnt_clr} = '0;
      {paddr, pwdata} = '0;
      timer_tick = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk(rd, 32'h0);
         chk(32'(err), 32'(i == 5));
      end
      $display("test reset done");
      apb(1'b1, stm_pkg::STM_CMPA_ADDR, 32'h40);
      apb(1'b1, stm_pkg::STM_CMPP_ADDR, 32'h1);
      for (int r = 0; r < 6; r++) begin
         apb(1'b1, stm_pkg::STM_CTRL_ADDR, {24'h0, stm_pkg::STM_MODE_PWM, ROWS[r][23:18]});
         apb(1'b1, stm_pkg::STM_CTRL_ADDR, {23'h0, 1'b1, stm_pkg::STM_MODE_PWM, ROWS[r][23:18]});
         apb(1'b1, stm_pkg::STM_FLAG_ADDR, 32'h3);
         @(posedge pclk);
         cnt_clr <= 1'b1;
         @(posedge pclk);
         cnt_clr <= 1'b0;
         wt(513);
         chk(32'(high_cnt), 32'(ROWS[r][17:2]));
         apb(1'b0, stm_pkg::STM_FLAG_ADDR, 32'h0);
         chk(rd & 32'h3, 32'(ROWS[r][1:0]));
         $display("test pwm row %0d done", r);
      end
      apb(1'b1, stm_pkg::STM_CTRL_ADDR, 32'h0);
      apb(1'b1, stm_pkg::STM_CMPA_ADDR, 32'h1E);
      apb(1'b1, stm_pkg::STM_CTRL_ADDR, 32'h2B8);
      apb(1'b1, stm_pkg::STM_FLAG_ADDR, 32'h3);
      @(posedge pclk);
      cnt_clr <= 1'b1;
      trig_go <= 1'b1;
      @(posedge pclk);
      cnt_clr <= 1'b0;
      trig_go <= 1'b0;
      wt(100);
      chk(32'(high_cnt >= 16'h001E && high_cnt <= 16'h0021), 32'h1);
      apb(1'b0, stm_pkg::STM_CTRL_ADDR, 32'h0);
      chk(32'(rd[stm_pkg::STM_RUN_BIT]), 32'h0);
      apb(1'b0, stm_pkg::STM_FLAG_ADDR, 32'h0);
      chk(rd & 32'h3, 32'h1);
      chk(32'(timer_out), 32'h0);
      apb(1'b1, stm_pkg::STM_CTRL_ADDR, 32'h1B8);
      wt(3);
      chk(32'(timer_out), 32'h1);
      apb(1'b1, stm_pkg::STM_CTRL_ADDR, 32'h0B8);
      wt(3);
      chk(32'(timer_out), 32'h0);
      $display("test single pulse done");
      apb(1'b1, stm_pkg::STM_CTRL_ADDR, 32'h040);
      apb(1'b1, stm_pkg::STM_CTRL_ADDR, 32'h140);
      wt(40);
      for (int e = 0; e < 4; e++) begin
         apb(1'b1, stm_pkg::STM_CTRL_ADDR, 32'h140 | 32'(e << 4));
         for (int lv = 1; lv >= 0; lv--) begin
            apb(1'b1, stm_pkg::STM_FLAG_ADDR, 32'h3);
            cap_level <= lv[0];
            wt(5);
            apb(1'b0, stm_pkg::STM_FLAG_ADDR, 32'h0);
            chk(32'(rd[0]), 32'(lv == 1 ? (e == 0 || e == 2) : (e == 1 || e == 2)));
            if (e == 0 && lv == 1) begin
               apb(1'b0, stm_pkg::STM_CMPA_ADDR, 32'h0);
               a_val = rd[15:0];
               apb(1'b0, stm_pkg::STM_CNT_ADDR, 32'h0);
               chk(32'(a_val > 16'h0000 && a_val < rd[15:0]), 32'h1);
               chk(32'(timer_out), 32'h0);
            end
         end
      end
      wt(300);
      apb(1'b0, stm_pkg::STM_FLAG_ADDR, 32'h0);
      chk(32'(rd[1]), 32'h1);
      apb(1'b0, stm_pkg::STM_CNT_ADDR, 32'h0);
      chk(32'(rd[15:8]), 32'h0);
      $display("test capture done");
      report_and_stop();
   end
endmodule : tb_standard_timer_pwm_pulse_capture
`default_nettype wire
